// [rtl/dpc_map.svh]
// Purpose: register offsets, field positions and reset values of the
//          pin configuration block
// Assumes: byte-wide register port with 8-bit addresses
// Notes:   definitions only
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

// register offsets
`define DPC_OFS_PINS_ONE_TWO   8'h1e
`define DPC_OFS_PIN_THREE      8'h1f
`define DPC_OFS_PINS_FIVE_SIX  8'h20
`define DPC_OFS_PORT_SELECT    8'h30
`define DPC_OFS_PIN_LEVELS     8'h31

// nibble positions of the two pin groups in a register
`define DPC_GRP_LO             0
`define DPC_GRP_HI             4
`define DPC_GRP_W              4

// bit of second_port_select in its register
`define DPC_PSEL_BIT           0

// writable bits of the pin-three register
`define DPC_MASK_PIN_THREE     8'h0f

// reset values
`define DPC_RST_PIN_REG        8'h00
`define DPC_RST_PSEL           1'b0
`define DPC_RST_PINS           8'h00

`endif

// [rtl/dpc_pkg.sv]
// Purpose: types shared by the pin configuration block
// Assumes: nothing
// Notes:   field order of a pin group runs high bit to low
package dpc_pkg;

	// one pin's four-bit configuration group
	typedef struct packed {
		logic level;
		logic remote;
		logic dir;
		logic en;
	} dpc_pin_cfg_t;

	// pin mode, coded as {dir, en}
	typedef enum logic [1:0] {
		DPC_MODE_FUNC   = 2'b00,
		DPC_MODE_SW_OUT = 2'b01,
		DPC_MODE_TRI    = 2'b10,
		DPC_MODE_SW_IN  = 2'b11
	} dpc_mode_t;

	// one register-port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dpc_bus_req_t;

endpackage : dpc_pkg

// [rtl/dpc_top.sv]
// Purpose: general-purpose pin configuration of a link deserializer
// Assumes: remote_i and func_i come from logic on clk_i; pin_in_i from pads
// Notes:   pin index 0..4 = primary pins 1,2,3,5,6; 5..7 = second port 1,2,3
// How it works
// - software level drives pin only in software-output mode, remote off.
// - remote bit set makes pin an output carrying the serializer value.
// - code {dir,en}: 00 functional, 10 tri-state, 01 sw out, 11 input.
// - port select moves pins 1-3 registers onto second-port pins.
// - reset clears all pin registers: functional, remote off, level 0.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "dpc_map.svh"

module dpc_top (
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 ce_i,
	input  wire dpc_pkg::dpc_bus_req_t bus_i,
	output var  logic [7:0]           rd_data_o,
	input  wire logic [7:0]           func_i,
	input  wire logic [7:0]           remote_i,
	input  wire logic [7:0]           pin_in_i,
	output var  logic [7:0]           pin_out_o,
	output var  logic [7:0]           pin_oe_o,
	output var  logic                 second_port_select_o
);
	import dpc_pkg::*;

	localparam int NPINS = 8;

	logic [7:0] pins_one_two_control;
	logic [7:0] pin_three_control;
	logic [7:0] pins_five_six_control;
	logic       second_port_select;
	logic [7:0] pin_sync1;
	logic [7:0] pin_sync2;

	// address decode
	wire logic hit_12  = bus_i.addr == `DPC_OFS_PINS_ONE_TWO;
	wire logic hit_3   = bus_i.addr == `DPC_OFS_PIN_THREE;
	wire logic hit_56  = bus_i.addr == `DPC_OFS_PINS_FIVE_SIX;
	wire logic hit_ps  = bus_i.addr == `DPC_OFS_PORT_SELECT;
	wire logic hit_lvl = bus_i.addr == `DPC_OFS_PIN_LEVELS;

	wire logic wr_12 = bus_i.wr & hit_12;
	wire logic wr_3  = bus_i.wr & hit_3;
	wire logic wr_56 = bus_i.wr & hit_56;
	wire logic wr_ps = bus_i.wr & hit_ps;

	// read selection; unmapped offsets read zero
	wire logic [7:0] psel_word =
		8'(second_port_select) << `DPC_PSEL_BIT;
	wire logic [7:0] rd_mux =
		hit_12  ? pins_one_two_control :
		hit_3   ? pin_three_control :
		hit_56  ? pins_five_six_control :
		hit_ps  ? psel_word :
		hit_lvl ? pin_sync2 : 8'h00;
	wire logic [7:0] next_rd_data = bus_i.rd ? rd_mux : 8'h00;

	// pin groups of each register
	wire dpc_pin_cfg_t cfg_one = dpc_pin_cfg_t'(
		pins_one_two_control[`DPC_GRP_LO +: `DPC_GRP_W]);
	wire dpc_pin_cfg_t cfg_two = dpc_pin_cfg_t'(
		pins_one_two_control[`DPC_GRP_HI +: `DPC_GRP_W]);
	wire dpc_pin_cfg_t cfg_three = dpc_pin_cfg_t'(
		pin_three_control[`DPC_GRP_LO +: `DPC_GRP_W]);
	wire dpc_pin_cfg_t cfg_five = dpc_pin_cfg_t'(
		pins_five_six_control[`DPC_GRP_LO +: `DPC_GRP_W]);
	wire dpc_pin_cfg_t cfg_six = dpc_pin_cfg_t'(
		pins_five_six_control[`DPC_GRP_HI +: `DPC_GRP_W]);
	wire dpc_pin_cfg_t cfg_off = dpc_pin_cfg_t'(4'h0);

	// steering of pins 1-3 groups between the two ports
	wire dpc_pin_cfg_t pin_cfg [NPINS];
	assign pin_cfg[0] = second_port_select ? cfg_off : cfg_one;
	assign pin_cfg[1] = second_port_select ? cfg_off : cfg_two;
	assign pin_cfg[2] = second_port_select ? cfg_off : cfg_three;
	assign pin_cfg[3] = cfg_five;
	assign pin_cfg[4] = cfg_six;
	assign pin_cfg[5] = second_port_select ? cfg_one : cfg_off;
	assign pin_cfg[6] = second_port_select ? cfg_two : cfg_off;
	assign pin_cfg[7] = second_port_select ? cfg_three : cfg_off;

	wire logic [7:0] next_pin_out;
	wire logic [7:0] next_pin_oe;

	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			wire dpc_mode_t mode = dpc_mode_t'(
				{pin_cfg[g].dir, pin_cfg[g].en});
			wire logic drives = (mode == DPC_MODE_FUNC) |
				(mode == DPC_MODE_SW_OUT);
			wire logic local_val =
				(mode == DPC_MODE_SW_OUT) ? pin_cfg[g].level :
				(mode == DPC_MODE_FUNC) ? func_i[g] : 1'b0;
			// remote control overrides every local mode
			assign next_pin_oe[g] = pin_cfg[g].remote | drives;
			assign next_pin_out[g] = pin_cfg[g].remote ?
				remote_i[g] : local_val;
		end
	endgenerate

	// register writes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pins_one_two_control  <= `DPC_RST_PIN_REG;
			pin_three_control     <= `DPC_RST_PIN_REG;
			pins_five_six_control <= `DPC_RST_PIN_REG;
			second_port_select    <= `DPC_RST_PSEL;
		end else if (ce_i) begin
			if (wr_12)
				pins_one_two_control <= bus_i.wdata;
			if (wr_3)
				pin_three_control <=
					bus_i.wdata & `DPC_MASK_PIN_THREE;
			if (wr_56)
				pins_five_six_control <= bus_i.wdata;
			if (wr_ps)
				second_port_select <= bus_i.wdata[`DPC_PSEL_BIT];
		end
	end

	// pad input synchroniser
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_sync1 <= `DPC_RST_PINS;
			pin_sync2 <= `DPC_RST_PINS;
		end else if (ce_i) begin
			pin_sync1 <= pin_in_i;
			pin_sync2 <= pin_sync1;
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data_o            <= 8'h00;
			pin_out_o            <= `DPC_RST_PINS;
			pin_oe_o             <= `DPC_RST_PINS;
			second_port_select_o <= `DPC_RST_PSEL;
		end else if (ce_i) begin
			rd_data_o            <= next_rd_data;
			pin_out_o            <= next_pin_out;
			pin_oe_o             <= next_pin_oe;
			second_port_select_o <= second_port_select;
		end
	end

endmodule : dpc_top
`default_nettype wire

// [tb/dpc_remote_model.sv]
// Purpose: remote serializer stand-in
// Assumes: pin values cross the link one clock late
// Notes: level_i is what the far side samples
`timescale 1ns/100ps
`default_nettype none
module dpc_remote_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] level_i,
	output var  logic [7:0] remote_o
);
	always_ff @(posedge clk_i) begin
		remote_o <= level_i;
	end
endmodule : dpc_remote_model
`default_nettype wire

// [tb/dpc_top_asserts.sv]
// Purpose: port checker of dpc_top
// Assumes: one clock, ce_i gates every update
// Notes: mirrors the pins five/six register
`timescale 1ns/100ps
`default_nettype none
module dpc_top_asserts (
	input wire logic                  clk_i,
	input wire logic                  rst_b_i,
	input wire logic                  ce_i,
	input wire dpc_pkg::dpc_bus_req_t bus_i,
	input wire logic [7:0]            rd_data_o,
	input wire logic [7:0]            func_i,
	input wire logic [7:0]            remote_i,
	input wire logic [7:0]            pin_out_o,
	input wire logic [7:0]            pin_oe_o,
	input wire logic                  second_port_select_o
);
	import dpc_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [7:0] grp;
	logic [3:0] e;
	// returns {oe, out}
	function automatic logic [1:0] pin(dpc_pin_cfg_t c, logic f, logic r);
		return c.remote ? {1'b1, r} : {!c.dir, !c.dir & (c.en ? c.level : f)};
	endfunction : pin
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			grp <= 8'h00;
			e <= 4'h0;
		end else if (ce_i) begin
			if (bus_i.wr && bus_i.addr == 8'h20)
				grp <= bus_i.wdata;
			e <= {pin(grp[7:4], func_i[4], remote_i[4]),
				pin(grp[3:0], func_i[3], remote_i[3])};
		end
	end
	a_pin_mode_map: assert property (
		{pin_oe_o[4], pin_out_o[4], pin_oe_o[3], pin_out_o[3]} == e)
		else $error("pins five/six off config");
	a_off_pin_quiet: assert property (
		(pin_out_o & ~pin_oe_o) == 8'h00) else $error("undriven pin high");
	a_reset_func_out: assert property (
		!$past(rst_b_i) && ce_i |=> pin_oe_o == 8'hff)
		else $error("no functional outputs after reset");
	a_port_two_idle: assert property (
		$past(rst_b_i) && $past(ce_i) && !second_port_select_o |->
		pin_oe_o[7:5] == 3'h7 && pin_out_o[7:5] == $past(func_i[7:5]))
		else $error("second port pins not idle");
	a_port_one_idle: assert property (
		$past(rst_b_i) && $past(ce_i) && second_port_select_o |->
		pin_oe_o[2:0] == 3'h7 && pin_out_o[2:0] == $past(func_i[2:0]))
		else $error("primary pins not idle");
	a_pin_three_top: assert property (
		ce_i && bus_i.rd && bus_i.addr == 8'h1f |=> rd_data_o[7:4] == 4'h0)
		else $error("reserved nibble not zero");
	a_group_readback: assert property (
		ce_i && bus_i.rd && bus_i.addr == 8'h20 |=> rd_data_o == grp)
		else $error("pins five/six readback wrong");
endmodule : dpc_top_asserts
bind dpc_top dpc_top_asserts i_chk (.*);
`default_nettype wire

// [tb/dpc_top_bench.sv]
// Purpose: self-checking bench of dpc_top
// Assumes: ce_i high except in the last write test, func_i 8'h02, remote level 8'h01
// Notes: rows hold {config, 0, oe[1:0], out[1:0]} of pins one/two
`timescale 1ns/100ps
`default_nettype none
module dpc_top_bench;
	import dpc_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_b_i = 1'b0;
	logic         ce_i = 1'b1;
	logic         second_port_select_o;
	dpc_bus_req_t bus_i = '0;
	logic [7:0]   rd_data_o, pin_out_o, pin_oe_o, remote_i;
	int           fail_count = 0;
	int           num_checks = 0;
	logic [15:0]  rows [5] =
		'{16'h000e, 16'h190d, 16'h3a00, 16'h960f, 16'hc208};
	always #10 clk_i = ~clk_i;
	dpc_remote_model i_rem (.clk_i(clk_i), .level_i(8'h01), .remote_o(remote_i));
	dpc_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .bus_i(bus_i),
		.rd_data_o(rd_data_o), .func_i(8'h02), .remote_i(remote_i),
		.pin_in_i(8'ha5), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.second_port_select_o(second_port_select_o));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_i);
		bus_i <= '{a, d, w, !w};
		@(posedge clk_i);
		bus_i <= '0;
		#1;
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(a, 8'h00, 1'b0);
		chk(rd_data_o, exp);
	endtask : rd
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk(pin_oe_o, 8'hff);
		rd(8'h1f, 8'h00);
		foreach (rows[i]) begin
			acc(8'h1e, rows[i][15:8], 1'b1);
			@(posedge clk_i);
			#1;
			chk({4'h0, pin_oe_o[1:0], pin_out_o[1:0]}, rows[i][7:0]);
			rd(8'h1e, rows[i][15:8]);
		end
		acc(8'h1f, 8'hf9, 1'b1);
		rd(8'h1f, 8'h09);
		acc(8'h20, 8'h96, 1'b1);
		rd(8'h20, 8'h96);
		rd(8'h31, 8'ha5);
		rd(8'h7f, 8'h00);
		acc(8'h30, 8'h01, 1'b1);
		acc(8'h1e, 8'h09, 1'b1);
		@(posedge clk_i);
		#1;
		chk({5'h0, pin_oe_o[5], pin_out_o[5], pin_out_o[0]}, 8'h06);
		chk({7'h0, second_port_select_o}, 8'h01);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(pin_oe_o, 8'h00);
		chk({7'h0, second_port_select_o}, 8'h00);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(8'h1e, 8'h00);
		// writes with the clock enable low must not land
		@(posedge clk_i);
		ce_i <= 1'b0;
		acc(8'h1e, 8'h55, 1'b1);
		@(posedge clk_i);
		ce_i <= 1'b1;
		rd(8'h1e, 8'h00);
		end_of_test();
	end
	initial begin
		repeat (2000) @(posedge clk_i);
		fail_count++;
		end_of_test();
	end
endmodule : dpc_top_bench
`default_nettype wire
